//--- inc/psr_cfg.svh
`ifndef PSR_CFG_SVH
`define PSR_CFG_SVH
// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define OFF_DICT_INDEX   12'h000
`define OFF_DICT_SUB     12'h004
`define OFF_DICT_WDATA   12'h008
`define OFF_DICT_CMD     12'h00C
`define OFF_DICT_RDATA   12'h010
`define OFF_STATUS       12'h014
`define OFF_INT_STATUS   12'h018
`define OFF_INT_ENABLE   12'h01C
`define OFF_INT_CLEAR    12'h020
`define OFF_LINK_CFG     12'h024
`define OFF_NV_DONE      12'h028
// ---------------------------------------------------------------
// dictionary objects and subindices
// ---------------------------------------------------------------
`define OBJ_SAVE         16'h1010
`define OBJ_DISCARD      16'h1011
`define OBJ_MARKER       16'h1020
`define OBJ_REBOOT       16'h2800
`define SUB_ALL          8'h01
`define SUB_COMM         8'h02
`define SUB_TUNING       8'h06
`define SUB_ETHERNET     8'h0C
`define SUB_MARK_DATE    8'h01
`define SUB_MARK_TIME    8'h02
`define SIG_SAVE         32'h6576_6173
`define SIG_DISCARD      32'h6461_6F6C
`define SIG_REBOOT       32'h746F_6F62
`define VAL_DONE         32'h0000_0001
`define VAL_BUSY         32'h0000_0000
`define TCP_PORT         16'h01F6
`define MAX_CONN         2'h1
// ---------------------------------------------------------------
// category mask bits
// ---------------------------------------------------------------
`define CAT_COMM         0
`define CAT_APP          1
`define CAT_CUST         2
`define CAT_DRIVE        3
`define CAT_TUNE         4
`define CAT_ETH          5
`define CAT_SAVE_ALL     6'h1F
`define CAT_DISC_ALL     6'h0F
// ---------------------------------------------------------------
// interrupt bits
// ---------------------------------------------------------------
`define IRQ_SAVE_DONE    0
`define IRQ_DISC_DONE    1
`define IRQ_MARK_CLR     2
`define IRQ_REBOOT       3
`endif

//--- inc/psr_pkg.sv
package psr_pkg;
  typedef enum {ST_IDLE, ST_SAVE, ST_DISCARD} op_e;
  typedef logic [5:0] cat_t;
endpackage

//--- inc/nv_req_if.sv
`timescale 1ns/1ps
interface nv_req_if;
  logic start;
  logic discard;
  psr_pkg::cat_t cats;
  logic busy;
  logic done;
  logic done_pin;
  modport ctrl (output start, output discard, output cats, input busy, input done);
  modport seq (input start, input discard, input cats, output busy, output done,
               input done_pin);
endinterface

//--- src/nv_sequencer.sv
`timescale 1ns/1ps
module nv_sequencer (
  input wire logic clk,
  input wire logic rst,
  nv_req_if.seq req,
  output logic nv_start,
  output logic nv_discard,
  output logic [5:0] nv_cats
);
  typedef struct packed {
    psr_pkg::op_e op;
    logic start;
    logic discard;
    psr_pkg::cat_t cats;
    logic done;
    logic [1:0] sync;
  } seq_s;
  seq_s s_reg;
  seq_s s_next;
  always_comb begin
    s_next = s_reg;
    s_next.start = 1'b0;
    s_next.done = 1'b0;
    s_next.sync = {s_reg.sync[0], req.done_pin};
    unique case (s_reg.op)
      psr_pkg::ST_IDLE: begin
        if (req.start) begin
          s_next.op = req.discard ? psr_pkg::ST_DISCARD : psr_pkg::ST_SAVE;
          s_next.start = 1'b1;
          s_next.discard = req.discard;
          s_next.cats = req.cats;
        end
      end
      psr_pkg::ST_SAVE, psr_pkg::ST_DISCARD: begin
        if (s_reg.sync[1]) begin
          s_next.op = psr_pkg::ST_IDLE;
          s_next.done = 1'b1;
        end
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '{op: psr_pkg::ST_IDLE, cats: '0, sync: '0, default: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end
  assign req.busy = (s_reg.op != psr_pkg::ST_IDLE);
  assign req.done = s_reg.done;
  assign nv_start = s_reg.start;
  assign nv_discard = s_reg.discard;
  assign nv_cats = s_reg.cats;
endmodule // nv_sequencer

//--- src/param_save_restore_ctrl.sv
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "psr_cfg.svh"
module param_save_restore_ctrl (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic NV_DONE_PIN,
  output logic NV_START,
  output logic NV_DISCARD,
  output logic [5:0] NV_CATS,
  output logic PENDING_DISCARD,
  output logic REBOOT,
  output logic IRQ
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] index;
    logic [7:0] sub;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [6:0][31:0] save_val;
    logic [6:0][31:0] disc_val;
    logic [31:0] mark_date;
    logic [31:0] mark_time;
    logic [2:0] save_slot;
    logic [5:0] pend_disc;
    logic [15:0] port;
    logic [1:0] conns;
    logic [3:0] int_status;
    logic [3:0] int_enable;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic reboot;
    logic irq;
    logic pend_out;
    logic wr_err;
  } ctrl_s;
  ctrl_s c_reg;
  ctrl_s c_next;
  nv_req_if req ();
  logic seq_start;
  logic seq_discard;
  psr_pkg::cat_t seq_cats;
  logic [5:0] nv_cats_w;
  logic nv_start_w;
  logic nv_discard_w;
  assign req.start = seq_start;
  assign req.discard = seq_discard;
  assign req.cats = seq_cats;
  assign req.done_pin = NV_DONE_PIN;
  nv_sequencer u_seq (
    .clk(SYS_CLK),
    .rst(RESET),
    .req(req),
    .nv_start(nv_start_w),
    .nv_discard(nv_discard_w),
    .nv_cats(nv_cats_w)
  );
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // maps a subindex to a slot 0..6, slot 7 means no such subindex
  function automatic logic [2:0] sub_slot(input logic [7:0] sub);
    if (sub >= `SUB_ALL && sub <= `SUB_TUNING) begin
      sub_slot = 3'(sub - `SUB_ALL);
    end else if (sub == `SUB_ETHERNET) begin
      sub_slot = 3'd6;
    end else begin
      sub_slot = 3'd7;
    end
  endfunction
  function automatic psr_pkg::cat_t slot_cats(input logic [2:0] slot, input logic disc);
    psr_pkg::cat_t m;
    m = '0;
    if (slot == 3'd0) begin
      m = disc ? `CAT_DISC_ALL : `CAT_SAVE_ALL;
    end else if (slot == 3'd6) begin
      m[`CAT_ETH] = 1'b1;
    end else if (slot != 3'd7) begin
      m[3'(slot - 3'd1)] = 1'b1;
    end
    slot_cats = m;
  endfunction
  // savable objects: the command objects, the reboot object, and the
  // generic dictionary range the marker watches
  function automatic logic is_savable(input logic [15:0] idx);
    is_savable = (idx >= 16'h2000) || (idx == `OBJ_SAVE) || (idx == `OBJ_DISCARD);
  endfunction
  // ---------------------------------------------------------------
  // apb slave and command decode
  // ---------------------------------------------------------------
  logic access;
  logic wr;
  logic rd;
  logic [2:0] slot;
  logic [3:0] events;
  always_comb begin
    c_next = c_reg;
    access = PSEL && PENABLE && !c_reg.pready;
    wr = access && PWRITE;
    rd = access && !PWRITE;
    slot = sub_slot(c_reg.sub);
    events = '0;
    seq_start = 1'b0;
    seq_discard = 1'b0;
    seq_cats = '0;
    c_next.pready = access;
    c_next.pslverr = 1'b0;
    c_next.reboot = 1'b0;
    // completion of the running nv operation
    if (req.done) begin
      if (c_reg.save_slot != 3'd7) begin
        c_next.save_val[c_reg.save_slot] = `VAL_DONE;
        events[`IRQ_SAVE_DONE] = 1'b1;
        c_next.save_slot = 3'd7;
      end else begin
        events[`IRQ_DISC_DONE] = 1'b1;
      end
    end
    if (wr) begin
      unique case (PADDR)
        `OFF_DICT_INDEX: c_next.index = PWDATA[15:0];
        `OFF_DICT_SUB: c_next.sub = PWDATA[7:0];
        `OFF_DICT_WDATA: c_next.wdata = PWDATA;
        `OFF_DICT_CMD: begin
          if (PWDATA[0]) begin
            // error bit tells about the latest dictionary write only
            c_next.wr_err = 1'b0;
            // dictionary write of wdata at index:sub
            if (is_savable(c_reg.index) && c_reg.index != `OBJ_MARKER &&
                !(c_reg.index == `OBJ_SAVE && c_reg.sub == `SUB_ALL)) begin
              c_next.mark_date = '0;
              c_next.mark_time = '0;
              events[`IRQ_MARK_CLR] = 1'b1;
            end
            if (c_reg.index == `OBJ_SAVE && slot != 3'd7) begin
              if (req.busy) begin
                c_next.wr_err = 1'b1;
              end else if (c_reg.wdata == `SIG_SAVE) begin
                c_next.save_val[slot] = `VAL_BUSY;
                c_next.save_slot = slot;
                seq_start = 1'b1;
                seq_cats = slot_cats(slot, 1'b0);
              end else begin
                c_next.save_val[slot] = c_reg.wdata;
              end
            end else if (c_reg.index == `OBJ_DISCARD && slot != 3'd7) begin
              if (req.busy) begin
                c_next.wr_err = 1'b1;
              end else if (c_reg.wdata == `SIG_DISCARD) begin
                seq_start = 1'b1;
                seq_discard = 1'b1;
                seq_cats = slot_cats(slot, 1'b1);
                // working values stay; only the restart takes effect
                c_next.pend_disc = c_reg.pend_disc | slot_cats(slot, 1'b1);
              end
              c_next.disc_val[slot] = c_reg.wdata;
            end else if (c_reg.index == `OBJ_MARKER && c_reg.sub == `SUB_MARK_DATE) begin
              c_next.mark_date = c_reg.wdata;
            end else if (c_reg.index == `OBJ_MARKER && c_reg.sub == `SUB_MARK_TIME) begin
              c_next.mark_time = c_reg.wdata;
            end else if (c_reg.index == `OBJ_REBOOT && c_reg.sub == `SUB_ALL &&
                         c_reg.wdata == `SIG_REBOOT) begin
              c_next.reboot = 1'b1;
              c_next.pend_disc = '0;
              events[`IRQ_REBOOT] = 1'b1;
            end else begin
              c_next.wr_err = 1'b1;
            end
          end
        end
        `OFF_INT_ENABLE: c_next.int_enable = PWDATA[3:0];
        `OFF_INT_CLEAR: c_next.int_status = c_reg.int_status & ~PWDATA[3:0];
        `OFF_LINK_CFG: begin
          if (PWDATA[15:0] == `TCP_PORT && PWDATA[17:16] <= `MAX_CONN) begin
            c_next.port = PWDATA[15:0];
            c_next.conns = PWDATA[17:16];
          end else begin
            c_next.pslverr = 1'b1;
          end
        end
        default: c_next.pslverr = 1'b1;
      endcase
    end
    // set wins over a clear in the same cycle
    c_next.int_status = c_next.int_status | events;
    // dictionary read lookup
    if (c_reg.index == `OBJ_SAVE && slot != 3'd7) begin
      c_next.rdata = c_next.save_val[slot];
    end else if (c_reg.index == `OBJ_DISCARD && slot != 3'd7) begin
      c_next.rdata = c_next.disc_val[slot];
    end else if (c_reg.index == `OBJ_MARKER && c_reg.sub == `SUB_MARK_DATE) begin
      c_next.rdata = c_next.mark_date;
    end else if (c_reg.index == `OBJ_MARKER && c_reg.sub == `SUB_MARK_TIME) begin
      c_next.rdata = c_next.mark_time;
    end else begin
      c_next.rdata = '0;
    end
    if (rd) begin
      unique case (PADDR)
        `OFF_DICT_INDEX: c_next.prdata = {16'h0000, c_reg.index};
        `OFF_DICT_SUB: c_next.prdata = {24'h00_0000, c_reg.sub};
        `OFF_DICT_WDATA: c_next.prdata = c_reg.wdata;
        `OFF_DICT_CMD: c_next.prdata = {30'h0000_0000, c_reg.wr_err, req.busy};
        `OFF_DICT_RDATA: c_next.prdata = c_reg.rdata;
        `OFF_STATUS: c_next.prdata = {24'h00_0000, c_reg.pend_disc, 1'b0, req.busy};
        `OFF_INT_STATUS: c_next.prdata = {28'h000_0000, c_reg.int_status};
        `OFF_INT_ENABLE: c_next.prdata = {28'h000_0000, c_reg.int_enable};
        `OFF_INT_CLEAR: c_next.prdata = '0;
        `OFF_LINK_CFG: c_next.prdata = {14'h0000, c_reg.conns, c_reg.port};
        default: begin
          c_next.prdata = '0;
          c_next.pslverr = 1'b1;
        end
      endcase
    end
    c_next.irq = |(c_next.int_status & c_next.int_enable);
    c_next.pend_out = |c_next.pend_disc;
  end
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      c_reg <= '0;
      c_reg.save_slot <= 3'd7;
      c_reg.port <= `TCP_PORT;
      c_reg.conns <= `MAX_CONN;
    end else begin
      c_reg <= c_next;
    end
  end
  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // nv sequencer drives its pins from its own flops; the rest come from c_reg
  assign PRDATA = c_reg.prdata;
  assign PREADY = c_reg.pready;
  assign PSLVERR = c_reg.pslverr;
  assign NV_START = nv_start_w;
  assign NV_DISCARD = nv_discard_w;
  assign NV_CATS = nv_cats_w;
  assign PENDING_DISCARD = c_reg.pend_out;
  assign REBOOT = c_reg.reboot;
  assign IRQ = c_reg.irq;
endmodule // param_save_restore_ctrl

//--- verification/nv_store_model.sv
`timescale 1ns/1ps
module nv_store_model (
  input wire logic clk,
  input wire logic start,
  input wire logic slow,
  output logic done_pin
);
  int cnt = 0;
  // storage engine: busy for a while, then flags done for four cycles, low again before next op
  always @(posedge clk) begin
    if (start === 1'b1) begin
      cnt <= slow ? 64 : 24;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign done_pin = (cnt > 0) && (cnt < 5);
endmodule // nv_store_model

//--- verification/param_save_restore_ctrl_sva.sv
`timescale 1ns/1ps
module param_save_restore_ctrl_sva (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic NV_START,
  input wire logic NV_DISCARD,
  input wire logic [5:0] NV_CATS,
  input wire logic REBOOT,
  input wire logic IRQ
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  AST_READY_ONE: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  AST_READY_LAT: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready late");
  AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
    else $error("error outside access");
  AST_START_CAUSE: assert property (NV_START |-> PREADY && $past(PSEL && PENABLE && PWRITE))
    else $error("start without write");
  AST_START_ONE: assert property (NV_START |=> !NV_START)
    else $error("start not a pulse");
  AST_CATS_SHAPE: assert property (NV_START |-> $onehot(NV_CATS) ||
    NV_CATS == (NV_DISCARD ? 6'h0F : 6'h1F))
    else $error("bad category set");
  AST_REBOOT_ONE: assert property (REBOOT |=> !REBOOT)
    else $error("restart not a pulse");
  AST_IDLE_RESET: assert property (disable iff (1'b0) RESET |=>
    !NV_START && !REBOOT && !IRQ && !PREADY)
    else $error("outputs active after reset");
  COV_SAVE: cover property (NV_START && !NV_DISCARD);
  COV_DISCARD: cover property (NV_START && NV_DISCARD);
  COV_ERR: cover property (PSLVERR);
endmodule // param_save_restore_ctrl_sva
bind param_save_restore_ctrl param_save_restore_ctrl_sva u_param_save_restore_ctrl_sva (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .NV_START(NV_START), .NV_DISCARD(NV_DISCARD),
  .NV_CATS(NV_CATS), .REBOOT(REBOOT), .IRQ(IRQ));

//--- verification/test_param_save_restore_ctrl.sv
`timescale 1ns/1ps
`include "psr_cfg.svh"
module test_param_save_restore_ctrl;
  logic SYS_CLK, RESET, PSEL, PENABLE, PWRITE, NV_DONE_PIN, slow;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic PREADY, PSLVERR, NV_START, NV_DISCARD, PENDING_DISCARD, REBOOT, IRQ, er, disc;
  logic [5:0] NV_CATS;
  psr_pkg::cat_t cats;
  int miscompares = 0;
  int total_checks = 0;
  int starts = 0;
  int boots = 0;
  param_save_restore_ctrl u_param_save_restore_ctrl (.SYS_CLK(SYS_CLK), .RESET(RESET),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .NV_DONE_PIN(NV_DONE_PIN),
    .NV_START(NV_START), .NV_DISCARD(NV_DISCARD), .NV_CATS(NV_CATS),
    .PENDING_DISCARD(PENDING_DISCARD), .REBOOT(REBOOT), .IRQ(IRQ));
  nv_store_model u_nv_store_model (.clk(SYS_CLK), .start(NV_START), .slow(slow),
    .done_pin(NV_DONE_PIN));
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  // records every storage request and restart pulse
  always @(posedge SYS_CLK) begin
    if (NV_START === 1'b1) begin
      starts <= starts + 1;
      cats <= NV_CATS;
      disc <= NV_DISCARD;
    end
    if (REBOOT === 1'b1) boots <= boots + 1;
  end
  // ------------------------------------------------------------
  // bus and compare helpers
  // ------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic hang(input string nm);
    $display("BAD %s expected done seen timeout", nm);
    miscompares++;
    complete_run();
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) hang("apb ready");
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
  endtask
  task automatic dwr(input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] d);
    apb(1'b1, `OFF_DICT_INDEX, {16'h0000, ix});
    apb(1'b1, `OFF_DICT_SUB, {24'h00_0000, sb});
    apb(1'b1, `OFF_DICT_WDATA, d);
    apb(1'b1, `OFF_DICT_CMD, 32'h0000_0001);
  endtask
  task automatic drd(input logic [15:0] ix, input logic [7:0] sb);
    apb(1'b1, `OFF_DICT_INDEX, {16'h0000, ix});
    apb(1'b1, `OFF_DICT_SUB, {24'h00_0000, sb});
    apb(1'b0, `OFF_DICT_RDATA, 32'h0000_0000);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_op(input logic dc, input logic rf, input logic [7:0] sb,
                      input psr_pkg::cat_t m);
    int n0;
    int i;
    n0 = starts;
    // only dictionary writes are used, no custom process data setup
    dwr(dc ? `OBJ_DISCARD : `OBJ_SAVE, sb, dc ? `SIG_DISCARD : `SIG_SAVE);
    if (rf) begin
      apb(1'b1, `OFF_DICT_CMD, 32'h0000_0001);
      apb(1'b0, `OFF_DICT_CMD, 32'h0000_0000);
      chk("refused while busy", 1, rd[1]);
    end
    if (!dc) begin
      apb(1'b0, `OFF_DICT_RDATA, 32'h0000_0000);
      chk("value while saving", 0, rd);
    end
    i = 0;
    do begin
      apb(1'b0, `OFF_DICT_CMD, 32'h0000_0000);
      i++;
    end while (rd[0] !== 1'b0 && i < 60);
    if (i >= 60) hang("storage op");
    if (!dc) begin
      apb(1'b0, `OFF_DICT_RDATA, 32'h0000_0000);
      chk("value after save", 1, rd);
    end
    chk("start count", n0 + 1, starts);
    chk("categories", m, cats);
    chk("discard flag", dc, disc);
  endtask
  task automatic t_cats(input logic dc);
    logic [7:0] sb [7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0C};
    psr_pkg::cat_t m [7] = '{6'h1F, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
    if (dc) m[0] = 6'h0F;
    for (int i = 0; i < 7; i++) t_op(dc, 1'b0, sb[i], m[i]);
  endtask
  task automatic t_marker();
    dwr(`OBJ_MARKER, `SUB_MARK_DATE, 32'h0001_0203);
    dwr(`OBJ_MARKER, `SUB_MARK_TIME, 32'h0000_0405);
    t_op(1'b0, 1'b0, 8'h01, 6'h1F);
    drd(`OBJ_MARKER, `SUB_MARK_DATE);
    chk("marker date", 32'h0001_0203, rd);
    drd(`OBJ_MARKER, `SUB_MARK_TIME);
    chk("marker time", 32'h0000_0405, rd);
    dwr(16'h2701, 8'h01, 32'h0000_0007);
    drd(`OBJ_MARKER, `SUB_MARK_TIME);
    chk("marker after write", 0, rd);
    apb(1'b0, `OFF_INT_STATUS, 32'h0000_0000);
    chk("marker event", 1, rd[2]);
    dwr(`OBJ_MARKER, `SUB_MARK_DATE, 32'h0001_0203);
    t_op(1'b0, 1'b0, 8'h03, 6'h02);
    drd(`OBJ_MARKER, `SUB_MARK_DATE);
    chk("marker after save", 0, rd);
  endtask
  task automatic t_irq();
    apb(1'b1, `OFF_INT_CLEAR, 32'h0000_000F);
    apb(1'b1, `OFF_INT_ENABLE, 32'h0000_0001);
    t_op(1'b0, 1'b0, 8'h02, 6'h01);
    chk("irq raised", 1, IRQ);
    apb(1'b1, `OFF_INT_CLEAR, 32'h0000_0001);
    chk("irq cleared", 0, IRQ);
    apb(1'b1, `OFF_INT_ENABLE, 32'h0000_0000);
    t_op(1'b0, 1'b0, 8'h05, 6'h08);
    chk("irq masked", 0, IRQ);
    apb(1'b0, `OFF_INT_STATUS, 32'h0000_0000);
    chk("save event", 1, rd[0]);
  endtask
  task automatic t_link();
    apb(1'b1, `OFF_LINK_CFG, 32'h0001_01F6);
    chk("port 502", 0, er);
    apb(1'b1, `OFF_LINK_CFG, 32'h0001_01F7);
    chk("port 503", 1, er);
    apb(1'b1, `OFF_LINK_CFG, 32'h0002_01F6);
    chk("two links", 1, er);
    apb(1'b0, 12'h030, 32'h0000_0000);
    chk("unmapped", 1, er);
  endtask
  task automatic t_reboot();
    int b0;
    b0 = boots;
    apb(1'b0, `OFF_STATUS, 32'h0000_0000);
    chk("pending set", 6'h3F, rd[7:2]);
    chk("pending pin", 1, PENDING_DISCARD);
    dwr(`OBJ_REBOOT, 8'h01, `SIG_SAVE);
    chk("no restart", b0, boots);
    dwr(`OBJ_REBOOT, 8'h01, `SIG_REBOOT);
    chk("restart", b0 + 1, boots);
    chk("pending after restart", 0, PENDING_DISCARD);
    drd(`OBJ_MARKER, `SUB_MARK_DATE);
    chk("marker date after restart", 0, rd);
  endtask
  initial begin
    RESET = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0000_0000;
    slow = 1'b0;
    repeat (4) @(posedge SYS_CLK);
    RESET <= 1'b0;
    chk("idle outputs", 0, {NV_START, REBOOT, IRQ, PENDING_DISCARD});
    t_link();
    t_cats(1'b0);
    t_marker();
    t_irq();
    slow <= 1'b1;
    t_op(1'b0, 1'b1, 8'h0C, 6'h20);
    slow <= 1'b0;
    t_cats(1'b1);
    t_reboot();
    complete_run();
  end
endmodule // test_param_save_restore_ctrl
